// ### core/ast_pkg.sv
package ast_pkg;

  localparam int CLK_MHZ        = 25;
  localparam int CLK_NS         = 1000 / CLK_MHZ;
  localparam int TICK_NS        = 250;
  localparam int CONV_NS        = 10000;
  localparam int SAMP_MIN_NS    = 10000;
  localparam int TMR_MIN_NS     = 500;

  localparam logic [7:0] ACC_STEP = 8'(CLK_NS);
  localparam logic [7:0] ACC_WRAP = 8'(TICK_NS);
  localparam logic [7:0] ACC_RST  = 8'h00;

  localparam logic [2:0] PULSE_CYC = 3'((TICK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] CONV_CYC  = 9'((CONV_NS + CLK_NS - 1) / CLK_NS);

  localparam logic [31:0] SAMP_MIN_CNT = 32'(SAMP_MIN_NS / TICK_NS - 1);
  localparam logic [31:0] TMR_MIN_CNT  = 32'(TMR_MIN_NS / TICK_NS - 1);
  localparam logic [31:0] CNT_RST      = 32'h0000_0000;

  localparam int NUM_CH     = 16;
  localparam int RES_W      = 12;
  localparam int CH_W       = 4;
  localparam int RANGE_W    = 3;
  localparam int FIFO_W     = CH_W + RES_W;
  localparam int FIFO_DEPTH = 8;
  localparam int NUM_FLAGS  = 4;
  localparam int NUM_DIO    = 4;

  localparam int FLG_TMR     = 0;
  localparam int FLG_TMR_OVR = 1;
  localparam int FLG_TRG     = 2;
  localparam int FLG_TRG_OVR = 3;

  localparam int PIN_SCLK = 0;
  localparam int PIN_TRIG = 1;
  localparam int PIN_DIN  = 2;
  localparam int PIN_W    = 2 + NUM_DIO;

  localparam logic [RANGE_W-1:0] RANGE_RST = 3'h0;
  localparam logic [NUM_DIO-1:0] DOUT_RST  = 4'h0;

  typedef enum logic [1:0] {
    AST_IDLE = 2'b00,
    AST_CONV = 2'b01,
    AST_GAP  = 2'b10
  } ast_conv_state_t;

endpackage : ast_pkg

// ### core/ast_fifo_if.sv
`timescale 1ns/1ps
interface ast_fifo_if #(
  parameter int W = 16
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ast_fifo_if

// ### core/ast_fifo.sv
`timescale 1ns/1ps
module ast_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic   mclk_i,
  input  wire logic   rst_i,
  ast_fifo_if.snk     wr,
  ast_fifo_if.src     rd
);
  localparam int AW = $clog2(D);
  localparam int CW = AW + 1;

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [CW-1:0] cnt;
  logic          out_valid;
  logic [W-1:0]  out_data;
  logic          push;
  logic          load;

  // The array is full at D words; the output register holds one more.
  assign wr.ready = (cnt < CW'(D));
  assign push     = wr.valid && wr.ready;
  assign load     = (cnt != '0) && (!out_valid || rd.ready);
  assign rd.valid = out_valid;
  assign rd.data  = out_data;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wptr] <= wr.data;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr <= '0;
      rptr <= '0;
      cnt  <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(D - 1)) ? '0 : wptr + 1'b1;
      end
      if (load) begin
        rptr <= (rptr == AW'(D - 1)) ? '0 : rptr + 1'b1;
      end
      cnt <= cnt + CW'(push) - CW'(load);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem[rptr];
    end else if (rd.ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : ast_fifo

// ### core/ast_ctrl.sv
`timescale 1ns/1ps
// Contract
// RQ1: Start conversions by software or periodic tick.
// RQ2: Software selects internal or external sampling clock.
// RQ3: Internal sampling period programmable in 250 ns.
// RQ4: External clock samples on each falling edge.
// RQ5: Interval timer period from 500 ns, 250 ns.
// RQ6: Timer reports expiry flag and overrun flag.
// RQ7: Timer output pulses low 250 ns per expiry; code holds it low 7 cycles (280 ns).
// RQ8: External trigger detected on falling edge.
// RQ9: Trigger sets flag; repeat before handling sets overrun.
// RQ10: 12-bit results, one conversion per 10 us.
// RQ11: Sixteen single-ended or eight differential channels.
// RQ12: Per-channel range from eight options, applied.
// RQ13: Four readable digital inputs, four drivable outputs.
// RQ14: Flags sticky until cleared; interrupt on enabled.
// RQ15: Down-counters on 250 ns tick, reload on expiry.
module ast_ctrl (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_i,
  input  wire logic                          periodic_i,
  input  wire logic                          src_ext_i,
  input  wire logic                          soft_start_i,
  input  wire logic [31:0]                   samp_period_i,
  input  wire logic                          timer_en_i,
  input  wire logic [31:0]                   timer_period_i,
  input  wire logic                          diff_i,
  input  wire logic [ast_pkg::CH_W-1:0]      chan_i,
  input  wire logic                          range_wr_i,
  input  wire logic [ast_pkg::CH_W-1:0]      range_ch_i,
  input  wire logic [ast_pkg::RANGE_W-1:0]   range_val_i,
  input  wire logic [ast_pkg::NUM_FLAGS-1:0] flag_clr_i,
  input  wire logic [ast_pkg::NUM_FLAGS-1:0] irq_en_i,
  input  wire logic                          dout_wr_i,
  input  wire logic [ast_pkg::NUM_DIO-1:0]   dout_val_i,
  input  wire logic                          ext_sclk_i,
  input  wire logic                          ext_trig_n_i,
  input  wire logic [ast_pkg::NUM_DIO-1:0]   din_pin_i,
  input  wire logic                          adc_done_i,
  input  wire logic [ast_pkg::RES_W-1:0]     adc_data_i,
  input  wire logic                          res_ready_i,
  output logic                               adc_start_o,
  output logic [ast_pkg::CH_W-1:0]           adc_chan_o,
  output logic [ast_pkg::RANGE_W-1:0]        adc_range_o,
  output logic                               adc_diff_o,
  output logic                               busy_o,
  output logic                               res_valid_o,
  output logic [ast_pkg::FIFO_W-1:0]         res_data_o,
  output logic                               timer_out_n_o,
  output logic [ast_pkg::NUM_FLAGS-1:0]      flags_o,
  output logic                               irq_o,
  output logic [ast_pkg::NUM_DIO-1:0]        din_o,
  output logic [ast_pkg::NUM_DIO-1:0]        dout_pin_o
);

  function automatic logic [31:0] clamp_min(input logic [31:0] val, input logic [31:0] lim);
    clamp_min = (val < lim) ? lim : val;
  endfunction : clamp_min

  ast_pkg::ast_conv_state_t              state;
  logic [ast_pkg::PIN_W-1:0]             pin_s1;
  logic [ast_pkg::PIN_W-1:0]             pin_s2;
  logic [ast_pkg::PIN_W-1:0]             pin_s3;
  logic                                  sclk_fall;
  logic                                  trig_fall;
  logic [7:0]                            acc;
  logic [8:0]                            acc_sum;
  logic                                  tick;
  logic [1:0]                            run;
  logic [31:0]                           load_val [2];
  logic [31:0]                           cnt [2];
  logic [1:0]                            expire;
  logic [2:0]                            pulse_cnt;
  logic [ast_pkg::NUM_FLAGS-1:0]         flags;
  logic [ast_pkg::NUM_FLAGS-1:0]         next_set;
  logic                                  pending;
  logic                                  samp_evt;
  logic                                  start_now;
  logic [8:0]                            gap_cnt;
  logic [ast_pkg::RANGE_W-1:0]           range_mem [ast_pkg::NUM_CH];
  logic [ast_pkg::CH_W-1:0]              sel_ch;
  ast_fifo_if #(.W(ast_pkg::FIFO_W))     push_if ();
  ast_fifo_if #(.W(ast_pkg::FIFO_W))     pop_if ();
  logic [8:0]                            since_start;

  // External pins pass two flip-flops; the third stage only feeds edge detection.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1 <= '1;
      pin_s2 <= '1;
      pin_s3 <= '1;
    end else begin
      pin_s1 <= {din_pin_i, ext_trig_n_i, ext_sclk_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign sclk_fall = pin_s3[ast_pkg::PIN_SCLK] && !pin_s2[ast_pkg::PIN_SCLK]; // RQ4
  assign trig_fall = pin_s3[ast_pkg::PIN_TRIG] && !pin_s2[ast_pkg::PIN_TRIG]; // RQ8

  // The 250 ns tick is not a whole number of clocks, so a phase accumulator spaces it 6 or 7 cycles.
  assign acc_sum = {1'b0, acc} + {1'b0, ast_pkg::ACC_STEP};
  assign tick    = (acc_sum >= {1'b0, ast_pkg::ACC_WRAP}); // RQ15

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      acc <= ast_pkg::ACC_RST;
    end else if (tick) begin
      acc <= 8'(acc_sum - {1'b0, ast_pkg::ACC_WRAP});
    end else begin
      acc <= acc_sum[7:0];
    end
  end

  a_tick_gap: assert property ( // RQ15
    @(posedge mclk_i) disable iff (rst_i)
    tick |=> !tick [*5] ##[1:2] tick)
    else $error("Tick spacing is not six or seven cycles.");

  // Counter 0 is the internal sampling clock, counter 1 the interval timer.
  assign run[0]      = periodic_i && !src_ext_i; // RQ2
  assign run[1]      = timer_en_i;
  assign load_val[0] = clamp_min(samp_period_i, ast_pkg::SAMP_MIN_CNT); // RQ3
  assign load_val[1] = clamp_min(timer_period_i, ast_pkg::TMR_MIN_CNT); // RQ5

  for (genvar g = 0; g < 2; g++) begin : g_ivl
    assign expire[g] = run[g] && tick && (cnt[g] == '0);

    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        cnt[g] <= ast_pkg::CNT_RST;
      end else if (!run[g]) begin
        cnt[g] <= load_val[g];
      end else if (tick) begin
        cnt[g] <= (cnt[g] == '0) ? load_val[g] : cnt[g] - 32'h0000_0001; // RQ15
      end
    end
  end

  // The timer pin is held low for the whole-cycle round-up of 250 ns after each expiry.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_cnt     <= 3'h0;
      timer_out_n_o <= 1'b1;
    end else if (expire[1]) begin
      pulse_cnt     <= ast_pkg::PULSE_CYC - 3'h1;
      timer_out_n_o <= 1'b0; // RQ7
    end else if (pulse_cnt != 3'h0) begin
      pulse_cnt     <= pulse_cnt - 3'h1;
      timer_out_n_o <= 1'b0;
    end else begin
      timer_out_n_o <= 1'b1;
    end
  end

  a_pulse_low: assert property ( // RQ7
    @(posedge mclk_i) disable iff (rst_i)
    $fell(timer_out_n_o) |-> !timer_out_n_o [*7] ##1 timer_out_n_o)
    else $error("Timer low pulse is not seven cycles.");

  // A new event while its flag still stands raises the overrun flag; the set beats a same-cycle clear.
  always_comb begin
    next_set                       = '0;
    next_set[ast_pkg::FLG_TMR]     = expire[1]; // RQ6
    next_set[ast_pkg::FLG_TMR_OVR] = expire[1] && flags[ast_pkg::FLG_TMR] && !flag_clr_i[ast_pkg::FLG_TMR]; // RQ6
    next_set[ast_pkg::FLG_TRG]     = trig_fall; // RQ9
    next_set[ast_pkg::FLG_TRG_OVR] = trig_fall && flags[ast_pkg::FLG_TRG] && !flag_clr_i[ast_pkg::FLG_TRG]; // RQ9
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr_i) | next_set; // RQ14
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags & irq_en_i); // RQ14
    end
  end

  assign flags_o = flags;

  a_trig_flag: assert property ( // RQ9
    @(posedge mclk_i) disable iff (rst_i)
    trig_fall |=> flags[ast_pkg::FLG_TRG])
    else $error("Trigger edge did not set its flag.");

  a_trig_ovr: assert property ( // RQ9
    @(posedge mclk_i) disable iff (rst_i)
    trig_fall && flags[ast_pkg::FLG_TRG] && !flag_clr_i[ast_pkg::FLG_TRG] |=> flags[ast_pkg::FLG_TRG_OVR])
    else $error("Repeated trigger did not set overrun.");

  a_tmr_ovr: assert property ( // RQ6
    @(posedge mclk_i) disable iff (rst_i)
    expire[1] && flags[ast_pkg::FLG_TMR] && !flag_clr_i[ast_pkg::FLG_TMR] |=> flags[ast_pkg::FLG_TMR_OVR])
    else $error("Repeated expiry did not set overrun.");

  a_flag_sticky: assert property ( // RQ14
    @(posedge mclk_i) disable iff (rst_i)
    flags[ast_pkg::FLG_TRG_OVR] && !flag_clr_i[ast_pkg::FLG_TRG_OVR] |=> flags[ast_pkg::FLG_TRG_OVR])
    else $error("Overrun flag dropped without a clear.");

  a_irq_follow: assert property ( // RQ14
    @(posedge mclk_i) disable iff (rst_i)
    (flags & irq_en_i) != '0 |=> irq_o ##0 $past(flags_o != '0))
    else $error("Interrupt did not follow an enabled flag.");

  // Per-channel range settings.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ast_pkg::NUM_CH; i++) begin
        range_mem[i] <= ast_pkg::RANGE_RST;
      end
    end else if (range_wr_i) begin
      range_mem[range_ch_i] <= range_val_i; // RQ12
    end
  end

  // Differential mode folds the channel number into the lower eight.
  assign sel_ch = diff_i ? {1'b0, chan_i[ast_pkg::CH_W-2:0]} : chan_i; // RQ11

  assign samp_evt  = periodic_i && (src_ext_i ? sclk_fall : expire[0]); // RQ1
  assign start_now = (state == ast_pkg::AST_IDLE) && pending && push_if.ready;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pending <= 1'b0;
    end else if (soft_start_i || samp_evt) begin
      pending <= 1'b1; // RQ1
    end else if (start_now) begin
      pending <= 1'b0;
    end
  end

  // The sequencer waits for room in the buffer, so a stalled reader holds sampling back.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state   <= ast_pkg::AST_IDLE;
      gap_cnt <= 9'h000;
    end else begin
      if (gap_cnt != 9'h000) begin
        gap_cnt <= gap_cnt - 9'h001;
      end
      case (state)
        ast_pkg::AST_IDLE: begin
          if (start_now) begin
            state   <= ast_pkg::AST_CONV;
            gap_cnt <= ast_pkg::CONV_CYC - 9'h001; // RQ10
          end
        end
        ast_pkg::AST_CONV: begin
          if (adc_done_i) begin
            state <= ast_pkg::AST_GAP;
          end
        end
        ast_pkg::AST_GAP: begin
          if (gap_cnt == 9'h000) begin
            state <= ast_pkg::AST_IDLE;
          end
        end
        default: begin
          state <= ast_pkg::AST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_start_o <= 1'b0;
      adc_chan_o  <= '0;
      adc_range_o <= ast_pkg::RANGE_RST;
      adc_diff_o  <= 1'b0;
    end else begin
      adc_start_o <= start_now;
      if (start_now) begin
        adc_chan_o  <= sel_ch;
        adc_range_o <= range_mem[sel_ch]; // RQ12
        adc_diff_o  <= diff_i; // RQ11
      end
    end
  end

  assign busy_o = (state != ast_pkg::AST_IDLE);

  // Each finished 12-bit result is tagged with its channel and pushed once.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      push_if.valid <= 1'b0;
      push_if.data  <= '0;
    end else begin
      push_if.valid <= (state == ast_pkg::AST_CONV) && adc_done_i;
      if ((state == ast_pkg::AST_CONV) && adc_done_i) begin
        push_if.data <= {adc_chan_o, adc_data_i}; // RQ10
      end
    end
  end

  ast_fifo #(
    .W (ast_pkg::FIFO_W),
    .D (ast_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .wr     (push_if.snk),
    .rd     (pop_if.src)
  );

  assign pop_if.ready = res_ready_i;
  assign res_valid_o  = pop_if.valid;
  assign res_data_o   = pop_if.data;

  // Helper counter of cycles since the last start.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      since_start <= 9'h1ff;
    end else if (adc_start_o) begin
      since_start <= 9'h000;
    end else if (since_start != 9'h1ff) begin
      since_start <= since_start + 9'h001;
    end
  end

  a_conv_gap: assert property ( // RQ10
    @(posedge mclk_i) disable iff (rst_i)
    adc_start_o |-> since_start >= (ast_pkg::CONV_CYC - 9'h001))
    else $error("Conversions closer than ten microseconds.");

  a_start_taken: assert property ( // RQ1
    @(posedge mclk_i) disable iff (rst_i)
    start_now |=> adc_start_o && busy_o && !$past(busy_o))
    else $error("Pending request did not start a conversion.");

  a_diff_chan: assert property ( // RQ11
    @(posedge mclk_i) disable iff (rst_i)
    adc_start_o && adc_diff_o |-> adc_chan_o < 4'h8)
    else $error("Differential channel above seven.");

  a_range_use: assert property ( // RQ12
    @(posedge mclk_i) disable iff (rst_i)
    adc_start_o && !$past(range_wr_i) |-> adc_range_o == range_mem[adc_chan_o])
    else $error("Range does not match channel setting.");

  a_ext_sample: assert property ( // RQ4
    @(posedge mclk_i) disable iff (rst_i)
    periodic_i && src_ext_i && sclk_fall |=> pending || adc_start_o)
    else $error("External falling edge did not request a sample.");

  // Digital inputs are synchronised, outputs written by software.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      din_o <= '0;
    end else begin
      din_o <= pin_s2[ast_pkg::PIN_DIN +: ast_pkg::NUM_DIO]; // RQ13
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dout_pin_o <= ast_pkg::DOUT_RST;
    end else if (dout_wr_i) begin
      dout_pin_o <= dout_val_i; // RQ13
    end
  end

  a_din_delay: assert property ( // RQ13
    @(posedge mclk_i) disable iff (rst_i)
    !$past(rst_i, 3) |-> din_o == $past(din_pin_i, 3))
    else $error("Digital input not three cycles behind pin.");

endmodule : ast_ctrl

// ### testbench/ast_adc_model.sv
`timescale 1ns/1ps
// Converter model: answers each start after a programmable delay with one result word.
module ast_adc_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  dly_i,
  input  wire logic        start_i,
  input  wire logic [3:0]  chan_i,
  input  wire logic [2:0]  range_i,
  input  wire logic        diff_i,
  output logic             done_o,
  output logic [11:0]      data_o
);
  logic        run;
  logic [7:0]  cnt;
  logic [11:0] word;

  // Outside a done pulse the data lines keep toggling so stale values cannot match.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run    <= 1'b0;
      cnt    <= 8'h00;
      word   <= 12'h000;
      done_o <= 1'b0;
      data_o <= 12'h5a5;
    end else begin
      done_o <= 1'b0;
      data_o <= ~data_o;
      if (start_i) begin
        run  <= 1'b1;
        cnt  <= dly_i;
        word <= {4'ha, diff_i, range_i, chan_i};
      end else if (run && cnt == 8'h00) begin
        run    <= 1'b0;
        done_o <= 1'b1;
        data_o <= word;
      end else if (run) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : ast_adc_model

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        periodic_i, src_ext_i, soft_start_i, timer_en_i, diff_i, range_wr_i, dout_wr_i;
  logic        ext_sclk_i, ext_trig_n_i, adc_done_i, res_ready_i;
  logic [31:0] samp_period_i, timer_period_i;
  logic [3:0]  chan_i, range_ch_i, flag_clr_i, irq_en_i, dout_val_i, din_pin_i;
  logic [2:0]  range_val_i, adc_range_o;
  logic [11:0] adc_data_i;
  logic        adc_start_o, adc_diff_o, busy_o, res_valid_o, timer_out_n_o, irq_o;
  logic [3:0]  adc_chan_o, flags_o, din_o, dout_pin_o;
  logic [15:0] res_data_o;
  logic [7:0]  dly;
  int          n_errors = 0;
  int          n_tests  = 0;
  int          gap      = 0;
  int          since    = 0;
  int          n_starts = 0;
  int          base, i, k;

  always #20 mclk_i = ~mclk_i;

  ast_ctrl uut (
    .mclk_i, .rst_i, .periodic_i, .src_ext_i, .soft_start_i, .samp_period_i, .timer_en_i,
    .timer_period_i, .diff_i, .chan_i, .range_wr_i, .range_ch_i, .range_val_i, .flag_clr_i,
    .irq_en_i, .dout_wr_i, .dout_val_i, .ext_sclk_i, .ext_trig_n_i, .din_pin_i, .adc_done_i,
    .adc_data_i, .res_ready_i, .adc_start_o, .adc_chan_o, .adc_range_o, .adc_diff_o, .busy_o,
    .res_valid_o, .res_data_o, .timer_out_n_o, .flags_o, .irq_o, .din_o, .dout_pin_o
  );

  ast_adc_model conv_model (
    .mclk_i(mclk_i), .rst_i(rst_i), .dly_i(dly), .start_i(adc_start_o), .chan_i(adc_chan_o),
    .range_i(adc_range_o), .diff_i(adc_diff_o), .done_o(adc_done_i), .data_o(adc_data_i)
  );

  // Counts starts and the spacing in cycles between the last two.
  always @(posedge mclk_i) begin
    since <= since + 1;
    if (adc_start_o === 1'b1) begin
      gap      <= since + 1;
      since    <= 0;
      n_starts <= n_starts + 1;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : cyc

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic sig(input int s);
    case (s)
      0: return adc_start_o;
      1: return res_valid_o;
      default: return ~timer_out_n_o;
    endcase
  endfunction : sig

  task automatic wait_for(input int s, input int lim);
    int t;
    t = 0;
    while (sig(s) !== 1'b1) begin
      cyc(1);
      t++;
      if (t > lim) begin
        chk(16'h0, 16'h1);
        end_of_test();
      end
    end
  endtask : wait_for

  task automatic conv(input logic [3:0] ch, input logic [2:0] rng, input logic dif);
    logic [3:0] ec;
    ec = dif ? {1'b0, ch[2:0]} : ch;
    chan_i = ch;
    diff_i = dif;
    soft_start_i = 1'b1;
    cyc(1);
    soft_start_i = 1'b0;
    wait_for(0, 300);
    chk(16'(adc_chan_o), 16'(ec));
    chk(16'(adc_range_o), 16'(rng));
    chk(16'(adc_diff_o), 16'(dif));
    chk(16'(busy_o), 16'h1);
    wait_for(1, 300);
    chk(res_data_o, {ec, 4'ha, dif, rng, ec});
    cyc(1);
  endtask : conv

  initial begin
    {periodic_i, src_ext_i, soft_start_i, timer_en_i, diff_i, range_wr_i, dout_wr_i} = 7'h00;
    ext_sclk_i = 1'b1;
    ext_trig_n_i = 1'b1;
    res_ready_i = 1'b1;
    samp_period_i = 32'h0000_004f;
    timer_period_i = 32'h0000_0001;
    {chan_i, range_ch_i, flag_clr_i, irq_en_i, dout_val_i, din_pin_i} = 24'h000000;
    range_val_i = 3'h0;
    dly = 8'h14;
    cyc(5);
    rst_i = 1'b0;
    cyc(1);
    chk({timer_out_n_o, flags_o, irq_o, adc_start_o, busy_o}, 16'h0080);
    cyc(2);
    dout_val_i = 4'ha;
    dout_wr_i = 1'b1;
    din_pin_i = 4'h5;
    cyc(1);
    dout_wr_i = 1'b0;
    chk(16'(din_o), 16'h0);
    cyc(3);
    chk(16'(dout_pin_o), 16'h000a);
    chk(16'(din_o), 16'h0005);
    // Every range code, one per channel, then a conversion on each.
    range_wr_i = 1'b1;
    for (i = 0; i < 8; i++) begin
      range_ch_i = 4'(i);
      range_val_i = 3'(7 - i);
      cyc(1);
    end
    range_wr_i = 1'b0;
    for (i = 0; i < 8; i++) begin
      conv(4'(i), 3'(7 - i), 1'b0);
    end
    conv(4'hf, 3'h0, 1'b0);
    conv(4'hc, 3'h3, 1'b1);
    // A request made during a conversion must wait out the ten microsecond spacing.
    soft_start_i = 1'b1;
    cyc(1);
    soft_start_i = 1'b0;
    wait_for(0, 300);
    soft_start_i = 1'b1;
    cyc(1);
    soft_start_i = 1'b0;
    wait_for(0, 600);
    cyc(1);
    chk(16'(gap >= 251), 16'h1);
    dly = 8'h14;
    cyc(300);
    // Interval timer at its minimum period with interrupts masked.
    timer_en_i = 1'b1;
    wait_for(2, 40);
    for (i = 0; sig(2) === 1'b1 && i < 20; i++) cyc(1);
    chk(16'(i), 16'h7);
    for (i = 0; sig(2) !== 1'b1 && i < 40; i++) cyc(1);
    chk(16'(i == 5 || i == 6), 16'h1);
    timer_en_i = 1'b0;
    cyc(20);
    chk(16'(flags_o), 16'h3);
    chk(16'(irq_o), 16'h0);
    irq_en_i = 4'h1;
    cyc(2);
    chk(16'(irq_o), 16'h1);
    flag_clr_i = 4'h3;
    cyc(1);
    flag_clr_i = 4'h0;
    cyc(2);
    chk({flags_o, irq_o}, 16'h0);
    // External trigger: event, then overrun, then clear.
    irq_en_i = 4'hc;
    ext_trig_n_i = 1'b0;
    cyc(6);
    chk(16'(flags_o), 16'h4);
    ext_trig_n_i = 1'b1;
    cyc(4);
    ext_trig_n_i = 1'b0;
    cyc(6);
    chk({flags_o, irq_o}, 16'h19);
    ext_trig_n_i = 1'b1;
    flag_clr_i = 4'hc;
    cyc(1);
    flag_clr_i = 4'h0;
    cyc(6);
    chk(16'(flags_o), 16'h0);
    // Internal periodic sampling while the result reader stalls.
    res_ready_i = 1'b0;
    periodic_i = 1'b1;
    base = n_starts;
    wait_for(0, 600);
    cyc(1);
    wait_for(0, 600);
    cyc(1);
    chk(16'(gap >= 493 && gap <= 507), 16'h1);
    cyc(5000);
    chk(16'(n_starts - base), 16'h9);
    periodic_i = 1'b0;
    res_ready_i = 1'b1;
    k = 0;
    for (i = 0; i < 12; i++) begin
      if (res_valid_o === 1'b1) begin
        k++;
        chk(res_data_o, {4'h4, 4'ha, 1'b1, 3'h3, 4'h4});
      end
      cyc(1);
    end
    chk(16'(k), 16'h9);
    cyc(300);
    // External sampling clock: one conversion per falling edge only.
    src_ext_i = 1'b1;
    periodic_i = 1'b1;
    base = n_starts;
    for (i = 0; i < 3; i++) begin
      ext_sclk_i = 1'b0;
      cyc(300);
      ext_sclk_i = 1'b1;
      cyc(300);
    end
    chk(16'(n_starts - base), 16'h3);
    end_of_test();
  end
endmodule : testbench
